/* File: rtl/rpc_pkg.sv */
// Notes on behaviour
// - Protection disabled: every access uses the default map, any privilege.
// - Enabled, background off: access outside every enabled region faults.
// - Enabled, background on: privileged misses use default map as region -1.
// - Enabled: unprivileged access hitting no enabled region faults.
// - Background enable ignored while protection is disabled.
// - Priority -1/-2 handlers bypass protection unless handler enable is set.
// - System control space is always execute-never and strongly ordered.
// - Enabled: vector table always permitted; system control space permitted except fetches, which fault.
// - Selector picks region for base/attribute access; only 0-7 written.
// - Base write, valid 0: update selected region base, selector unchanged.
// - Base write, valid 1: load selector from region field, update that base.
// - Base read: valid bit zero, region field shows selector.
// - Base field spans bits 31 to N, bits N-1 to 5 reserved.
// - 4GB region ignores base field and covers whole map from zero.
// - Attribute/size register takes word and halfword writes.
// - Region size is two to the size field plus one; minimum 32 bytes.
// - Overlapping enabled regions: highest-numbered match supplies attributes.
package rpc_pkg;
   localparam int unsigned NUM_REGIONS = 8;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SELECT = 12'h004;
   localparam logic [11:0] OFS_BASE = 12'h008;
   localparam logic [11:0] OFS_ATTR = 12'h00C;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_HIGH_PRI_BIT = 1;
   localparam int CTRL_BACKGROUND_BIT = 2;
   localparam int BASE_VALID_BIT = 4;
   localparam int BASE_ADDR_LSB = 5;
   localparam int ATTR_ENABLE_BIT = 0;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_XN_BIT = 28;
   localparam logic [4:0] SIZE_MIN = 5'h04;
   localparam logic [4:0] SIZE_FULL = 5'h1F;
   localparam logic [31:0] BASE_WRITE_MASK = 32'hFFFFFFE0;
   localparam logic [31:0] ATTR_WRITE_MASK = 32'h17FFFF3F;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   // System control space and vector table windows
   localparam logic [31:0] SCS_BASE = 32'hE000E000;
   localparam logic [31:0] SCS_LAST = 32'hE000EFFF;
   localparam logic [31:0] VECTOR_LAST = 32'h000003FF;
endpackage

/* File: rtl/rpc_region_match.sv */
`timescale 1ns/1ns
// One region's hit test against a fetch or data address
module rpc_region_match (
   input wire logic [31:0] base,
   input wire logic [31:0] attr,
   input wire logic [31:0] addr,
   output logic hit
);
   import rpc_pkg::*;
   logic [4:0] size_code;
   logic [31:0] mask;
   always_comb begin
      size_code = attr[ATTR_SIZE_LSB +: 5];
      // Size 2^(size+1); mask keeps bits at and above N
      mask = 32'hFFFFFFFF << (6'(size_code) + 6'h01);
      if (size_code < SIZE_MIN) begin
         mask = BASE_WRITE_MASK;
      end
      if (size_code == SIZE_FULL) begin
         hit = attr[ATTR_ENABLE_BIT];
      end else begin
         hit = attr[ATTR_ENABLE_BIT] && ((addr & mask) == (base & mask));
      end
   end
endmodule // rpc_region_match

/* File: rtl/rpc_region_protection.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module rpc_region_protection (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic acc_valid,
   input wire logic [31:0] acc_addr,
   input wire logic acc_privileged,
   input wire logic acc_fetch,
   input wire logic acc_high_priority,
   output logic acc_done,
   output logic acc_fault,
   output logic acc_default_map,
   output logic acc_execute_never,
   output logic acc_strongly_ordered,
   output logic [3:0] acc_region,
   output logic [15:0] acc_attributes
);
   import rpc_pkg::*;

   typedef struct packed {
      logic enable;
      logic high_pri;
      logic background;
      logic [2:0] select;
      logic [NUM_REGIONS-1:0][31:0] base;
      logic [NUM_REGIONS-1:0][31:0] attr;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic done;
      logic fault;
      logic default_map;
      logic xn;
      logic so;
      logic [3:0] region;
      logic [15:0] attributes;
   } rpc_state_type;

   rpc_state_type state;
   rpc_state_type next_state;
   logic [NUM_REGIONS-1:0] hit;
   logic [31:0] wmask;
   logic [31:0] attr_new;
   logic [2:0] target;
   logic setup;
   logic protect_on;
   logic any_hit;
   logic [2:0] top;
   logic in_scs;
   logic in_vectors;

   // One matcher per region
   for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_match
      rpc_region_match u_match (
         .base(state.base[i]),
         .attr(state.attr[i]),
         .addr(acc_addr),
         .hit(hit[i])
      );
   end

   // Byte lane mask built from the APB strobes
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{pstrb[b]}};
      end
   end

   // Highest-numbered hit wins on overlap
   always_comb begin
      any_hit = |hit;
      top = 3'h0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
         if (hit[r]) begin
            top = 3'(r);
         end
      end
   end

   always_comb begin
      in_scs = (acc_addr >= SCS_BASE) && (acc_addr <= SCS_LAST);
      in_vectors = acc_addr <= VECTOR_LAST;
      // High-priority handlers skip checking unless allowed
      protect_on = state.enable && (!acc_high_priority || state.high_pri);
   end

   always_comb begin
      next_state = state;
      setup = psel && !penable;
      target = (pwdata[BASE_VALID_BIT]) ? pwdata[2:0] : state.select;
      attr_new = (state.attr[state.select] & ~wmask) | (pwdata & wmask);
      // Access phase: one wait-free cycle, answer registered
      next_state.ready = setup;
      next_state.slverr = 1'b0;
      if (setup) begin
         next_state.rdata = RESET_WORD;
         if (!(paddr == OFS_CTRL || paddr == OFS_SELECT || paddr == OFS_BASE
               || paddr == OFS_ATTR)) begin
            next_state.slverr = 1'b1; // unmapped offset
         end
      end
      // Writes land only at the completing edge, with the request still held
      if (psel && penable && state.ready && pwrite) begin
         begin
            unique case (paddr)
               OFS_CTRL: begin
                  if (pstrb[0]) begin
                     next_state.enable = pwdata[CTRL_ENABLE_BIT];
                     next_state.high_pri = pwdata[CTRL_HIGH_PRI_BIT];
                     next_state.background = pwdata[CTRL_BACKGROUND_BIT];
                  end
               end
               OFS_SELECT: begin
                  // Only three bits kept; values above 7 wrap
                  if (pstrb[0]) begin
                     next_state.select = pwdata[2:0];
                  end
               end
               OFS_BASE: begin
                  // Full word only; with the valid bit set, base and selector move together
                  if (&pstrb) begin
                     if (pwdata[BASE_VALID_BIT]) begin
                        next_state.select = pwdata[2:0];
                     end
                     next_state.base[target] = pwdata & BASE_WRITE_MASK;
                  end
               end
               OFS_ATTR: begin
                  next_state.attr[state.select] = attr_new & ATTR_WRITE_MASK;
               end
               default: begin
               end
            endcase
         end
      end
      // Read data captured at setup so it stands with pready
      if (setup && !pwrite) begin
         begin
            unique case (paddr)
               OFS_CTRL: begin
                  next_state.rdata = {29'h0, state.background, state.high_pri,
                                      state.enable};
               end
               OFS_SELECT: begin
                  next_state.rdata = {29'h0, state.select};
               end
               OFS_BASE: begin
                  // Valid bit reads zero
                  next_state.rdata = state.base[state.select] | {29'h0, state.select};
               end
               OFS_ATTR: begin
                  next_state.rdata = state.attr[state.select];
               end
               default: begin
               end
            endcase
         end
      end

      // Access check, answered one cycle after acc_valid
      next_state.done = acc_valid;
      next_state.fault = 1'b0;
      next_state.default_map = 1'b0;
      next_state.region = 4'h0;
      next_state.attributes = 16'h0000;
      next_state.xn = 1'b0;
      next_state.so = 1'b0;
      if (acc_valid) begin
         if (!protect_on) begin
            next_state.default_map = 1'b1;
         end else if (in_scs || in_vectors) begin
            next_state.default_map = 1'b1;
         end else if (any_hit) begin
            next_state.region = {1'b0, top};
            next_state.attributes = state.attr[top][31:16];
            next_state.xn = state.attr[top][ATTR_XN_BIT];
            next_state.fault = acc_fetch && state.attr[top][ATTR_XN_BIT];
         end else if (acc_privileged && state.background) begin
            next_state.default_map = 1'b1;
            next_state.region = 4'hF; // Region -1
         end else begin
            next_state.fault = 1'b1;
         end
         // Control space always non-executable and strongly ordered
         if (in_scs) begin
            next_state.xn = 1'b1;
            next_state.so = 1'b1;
            next_state.fault = acc_fetch;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Every output straight from the state flops
   assign prdata = state.rdata;
   assign pready = state.ready;
   assign pslverr = state.slverr;
   assign acc_done = state.done;
   assign acc_fault = state.fault;
   assign acc_default_map = state.default_map;
   assign acc_execute_never = state.xn;
   assign acc_strongly_ordered = state.so;
   assign acc_region = state.region;
   assign acc_attributes = state.attributes;
endmodule // rpc_region_protection

/* File: tb/rpc_core_model.sv */
`timescale 1ns/1ns
// Core side: one access check at a time, address scrambled when idle
module rpc_core_model (
   input wire logic pclk,
   input wire logic acc_done,
   output logic acc_valid,
   output logic [31:0] acc_addr,
   output logic acc_privileged,
   output logic acc_fetch,
   output logic acc_high_priority
);
   initial begin
      acc_valid = 1'b0;
      acc_addr = 32'h0;
      {acc_privileged, acc_fetch, acc_high_priority} = 3'h0;
   end
   // Kind is {privileged, fetch, high priority}; results land after the next edge
   task automatic issue(input logic [31:0] a, input logic [2:0] k);
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      {acc_privileged, acc_fetch, acc_high_priority} <= k;
      @(posedge pclk);
      acc_valid <= 1'b0;
      acc_addr <= ~a; // Stale address must not look valid
      @(negedge pclk);
   endtask
endmodule // rpc_core_model

/* File: tb/rpc_region_protection_assertions.sv */
`timescale 1ns/1ns
module rpc_region_protection_assertions
   import rpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic acc_valid,
   input wire logic [31:0] acc_addr,
   input wire logic acc_privileged,
   input wire logic acc_high_priority,
   input wire logic acc_done,
   input wire logic acc_fault,
   input wire logic acc_default_map,
   input wire logic acc_execute_never,
   input wire logic acc_strongly_ordered,
   input wire logic [3:0] acc_region
);
   logic en, hp, bg, scs, rd_setup;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign scs = acc_addr >= SCS_BASE && acc_addr <= SCS_LAST;
   assign rd_setup = psel && !penable && !pwrite;
   // Shadow of control bits, taken only at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {bg, hp, en} <= 3'h0;
      end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
         {bg, hp, en} <= pwdata[2:0];
      end
   end
   a_result_follows: assert property (acc_valid |=> acc_done) else $error("no access result");
   a_off_default: assert property (acc_valid && !en |=> acc_default_map && !acc_fault)
      else $error("disabled access not on default map");
   a_bg_priv_only: assert property (acc_done && acc_region == 4'hF |-> $past(acc_privileged) && bg && en)
      else $error("background used wrongly");
   a_hp_bypass: assert property (acc_valid && acc_high_priority && !hp |=> !acc_fault)
      else $error("high priority access faulted");
   a_scs_xn: assert property (acc_valid && scs |=> acc_execute_never && acc_strongly_ordered)
      else $error("system space attributes missing");
   a_fixed_allowed: assert property (acc_valid && en && (scs || acc_addr <= VECTOR_LAST) |=> !acc_fault)
      else $error("fixed area access faulted");
   a_base_read: assert property (rd_setup && paddr == OFS_BASE |=> pready && !prdata[4])
      else $error("base read shows valid bit");
   a_ctrl_reserved: assert property (rd_setup && paddr == OFS_CTRL |=> pready && prdata[31:3] == 29'h0)
      else $error("control reserved bits nonzero");
endmodule // rpc_region_protection_assertions
bind rpc_region_protection rpc_region_protection_assertions rpc_region_protection_assertions_i (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import rpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, acc_addr;
   logic [3:0] pstrb, acc_region;
   logic acc_valid, acc_privileged, acc_fetch, acc_high_priority, acc_done, acc_fault;
   logic acc_default_map, acc_execute_never, acc_strongly_ordered;
   logic [15:0] acc_attributes;
   int errors, checked;
   rpc_region_protection rpc_region_protection_i (.*);
   rpc_core_model rpc_core_model_i (.*);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Setup then access; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Look while the answer stands, mid-cycle, then complete at the next rising edge
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
      end
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      {psel, penable} <= 2'h0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd, e);
   endtask
   // Region E in the expectation means the region number is not judged
   task automatic acc(input logic [31:0] a, input logic [2:0] k, input logic f, input logic [3:0] r);
      rpc_core_model_i.issue(a, k);
      chk({26'h0, acc_done, acc_fault, r == 4'hE ? 4'hE : acc_region}, {26'h0, 1'b1, f, r});
   endtask
   task automatic s_regs;
      rdchk(OFS_BASE, 32'h0);
      apb(1'b1, OFS_CTRL, 32'hFFFFFFF8, 4'hF);
      rdchk(OFS_CTRL, 32'h0);
      apb(1'b1, OFS_SELECT, 32'h3, 4'hF);
      apb(1'b1, OFS_BASE, 32'h2000000F, 4'hF);
      rdchk(OFS_BASE, 32'h20000003);
      apb(1'b1, OFS_BASE, 32'h40000015, 4'hF);
      rdchk(OFS_SELECT, 32'h5);
      apb(1'b1, OFS_ATTR, 32'h10000013, 4'h3);
      rdchk(OFS_ATTR, 32'h13);
      apb(1'b1, OFS_ATTR, 32'h10000000, 4'hC);
      rdchk(OFS_ATTR, 32'h10000013);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   // Region 5 is 1KB XN, region 6 a 1GB overlap above it
   task automatic s_access;
      apb(1'b1, OFS_BASE, 32'h40000016, 4'hF);
      apb(1'b1, OFS_ATTR, 32'h0000003B, 4'hF);
      apb(1'b1, OFS_CTRL, 32'h1, 4'hF);
      acc(32'h40000100, 3'b110, 1'b0, 4'h6);
      chk({15'h0, acc_default_map, acc_attributes}, 32'h0);
      acc(32'h90000000, 3'b000, 1'b1, 4'hE);
      acc(32'h90000000, 3'b100, 1'b1, 4'hE);
      acc(32'h90000000, 3'b001, 1'b0, 4'hE);
      acc(32'hE000E010, 3'b000, 1'b0, 4'hE);
      chk({30'h0, acc_execute_never, acc_strongly_ordered}, 32'h3);
      acc(32'h00000100, 3'b000, 1'b0, 4'hE);
      apb(1'b1, OFS_CTRL, 32'h5, 4'hF);
      acc(32'h90000000, 3'b100, 1'b0, 4'hF);
      chk({15'h0, acc_default_map, acc_attributes}, 32'h00010000);
      acc(32'h90000000, 3'b000, 1'b1, 4'hE);
      acc(32'h40000100, 3'b100, 1'b0, 4'h6);
      apb(1'b1, OFS_CTRL, 32'h4, 4'hF);
      acc(32'h90000000, 3'b000, 1'b0, 4'hE);
      apb(1'b1, OFS_CTRL, 32'h3, 4'hF);
      acc(32'h90000000, 3'b001, 1'b1, 4'hE);
   endtask
   task automatic close_out;
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      s_regs;
      s_access;
      close_out;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      close_out;
   end
endmodule // tb_top
